/* File: shared/frc_pkg.sv */
package frc_pkg;
  // Word width and address width of the largest organisation
  localparam int DATA_W = 72;
  localparam int ADDR_W = 14;
  // Fall-through load happens on this rising read edge
  localparam logic [1:0] FT_EDGES = 2'h3;
  // Number of latched static configuration bits
  localparam int CFG_W = 6;
  // Field positions inside the static configuration word
  localparam int CFG_OUT_W = 0;
  localparam int CFG_IN_W = 1;
  localparam int CFG_BUS_M = 2;
  localparam int CFG_BYTE_O = 3;
  localparam int CFG_FLAG_T = 4;
  localparam int CFG_PARITY = 5;
  // Default almost-empty and almost-full offsets after full reset
  localparam logic [13:0] AE_OFF_DEF = 14'h007f;
  localparam logic [13:0] AF_OFF_DEF = 14'h007f;
  // Read side states, one-hot
  typedef enum logic [2:0] {
    RD_NORMAL = 3'h1,
    RD_MARKED = 3'h2,
    RD_REPLAY = 3'h4
  } rd_state_type;
endpackage

/* File: rtl/frc_ctrl.sv */
`timescale 1ns/1ps
// Summary of operation
// - Full reset zeroes pointers, sets level flags
// - Mode pin low: standard, empty low, full high
// - Mode pin high: fall-through, ready high, room low
// - Static configuration latched only during full reset
// - Full reset independent of port clocks, clears output
// - Partial reset keeps mode, flags to empty state
// - Partial reset keeps offsets, clears output register
// - Async write: each strobe rise stores a word
// - Async write: full flag from direct pointers
// - Async read: each strobe rise delivers next word
// - Async read uses oe; sync uses read select
// - Async read: empty flag from direct pointers
// - Marked, replay low: read pointer back to mark
// - Standard: empty low during replay, then marked word
// - Fall-through: ready high, then marked word loaded
// - Mark edge records output word, enters marked mode
// - Writes never pass the marked location
// - Mark held high; falling edge with mark low exits
// - Fall-through first word after three read edges
// - Mode pin shifts offsets in when serial selected
module frc_ctrl #(
  parameter int ADDR_W = frc_pkg::ADDR_W,
  parameter int DATA_W = frc_pkg::DATA_W
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic full_reset_n,
  input wire logic partial_reset_n,
  input wire logic fallthrough_serial_pin,
  input wire logic serial_load_sel,
  input wire logic serial_clk_pin,
  input wire logic serial_enable_n,
  input wire logic write_async_sel_n,
  input wire logic read_async_sel_n,
  input wire logic out_width_sel,
  input wire logic in_width_sel,
  input wire logic bus_match_sel,
  input wire logic byte_order_sel,
  input wire logic flag_timing_sel,
  input wire logic interspersed_parity_sel,
  input wire logic wclk_pin,
  input wire logic wen_n,
  input wire logic [DATA_W-1:0] d_in_bus,
  input wire logic rclk_pin,
  input wire logic ren_n,
  input wire logic read_select_n,
  input wire logic oe_n,
  input wire logic mark,
  input wire logic replay_strobe_n,
  output logic [DATA_W-1:0] q_out_bus,
  output logic q_out_en,
  output logic empty_flag_n,
  output logic full_flag_n,
  output logic almost_empty_n,
  output logic almost_full_n,
  output logic half_level_n,
  output logic fallthrough_timing,
  output logic [frc_pkg::CFG_W-1:0] static_cfg,
  output logic [2*ADDR_W-1:0] offset_word
);
  localparam int PW = ADDR_W + 1;
  localparam int DEPTH = 1 << ADDR_W;
  // Depth and half depth at pointer width
  localparam logic [PW-1:0] DEPTH_P = PW'(DEPTH);
  localparam logic [PW-1:0] HALF_P = PW'(DEPTH / 2);
  localparam logic [PW-1:0] ONE_P = PW'(1);
  // Binary to gray and back
  function automatic logic [PW-1:0] bin2gray(input logic [PW-1:0] b);
    bin2gray = b ^ (b >> 1);
  endfunction
  function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
    logic [PW-1:0] b;
    b = g;
    for (int i = PW - 2; i >= 0; i--) b[i] = b[i+1] ^ g[i];
    gray2bin = b;
  endfunction
  // Storage array, no reset needed on contents
  logic [DATA_W-1:0] mem [0:DEPTH-1];
  // Previous pin samples for edge detection
  logic wclk_q_r, rclk_q_r, sclk_q_r;
  logic wr_rise, rd_rise, rd_fall, sc_rise;
  // Reset conditions seen on the control pins
  logic full_rst, any_rst;
  // Configuration group, latched at full reset
  logic fallthrough_timing_r, fallthrough_timing_nxt, wr_async_r, wr_async_nxt;
  logic rd_async_r, rd_async_nxt, serial_sel_r, serial_sel_nxt;
  logic [frc_pkg::CFG_W-1:0] static_cfg_r, static_cfg_nxt;
  logic [2*ADDR_W-1:0] offset_r, offset_nxt;
  // Write group
  logic [PW-1:0] wptr_r, wptr_nxt, wgray_r, wgray_nxt, rgray_s1_r, rgray_s2_r, rptr_seen;
  logic wr_full, wr_blocked, wr_go;
  // Read group
  frc_pkg::rd_state_type state_r, state_nxt;
  logic [PW-1:0] rptr_r, rptr_nxt, rgray_r, rgray_nxt, mark_ptr_r, mark_ptr_nxt;
  logic [PW-1:0] wgray_s1_r, wgray_s2_r, wptr_seen;
  logic ov_r, ov_nxt, rcs_on_r, rcs_on_nxt, rd_avail, rd_req;
  logic [1:0] ft_cnt_r, ft_cnt_nxt;
  logic [DATA_W-1:0] q_r, q_nxt;
  // Flag group, all outputs registered
  logic ef_r, ef_nxt, ff_r, ff_nxt, ae_r, ae_nxt, af_r, af_nxt, hf_r, hf_nxt;
  logic oe_r, oe_nxt, ft_mode;
  logic [PW-1:0] level;

  // Pin edges; inputs are already synchronous to mclk
  assign wr_rise = wclk_pin & ~wclk_q_r;
  assign rd_rise = rclk_pin & ~rclk_q_r;
  assign rd_fall = ~rclk_pin & rclk_q_r;
  assign sc_rise = serial_clk_pin & ~sclk_q_r;
  assign full_rst = ~full_reset_n;
  assign any_rst = full_rst | ~partial_reset_n;
  // Edge sample registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wclk_q_r <= 1'b0;
      rclk_q_r <= 1'b0;
      sclk_q_r <= 1'b0;
    end else begin
      wclk_q_r <= wclk_pin;
      rclk_q_r <= rclk_pin;
      sclk_q_r <= serial_clk_pin;
    end
  end

  // Configuration next state: latch only while full reset is low
  always_comb begin
    fallthrough_timing_nxt = fallthrough_timing_r;
    wr_async_nxt = wr_async_r;
    rd_async_nxt = rd_async_r;
    serial_sel_nxt = serial_sel_r;
    static_cfg_nxt = static_cfg_r;
    offset_nxt = offset_r;
    if (full_rst) begin
      fallthrough_timing_nxt = fallthrough_serial_pin;
      wr_async_nxt = ~write_async_sel_n;
      rd_async_nxt = ~read_async_sel_n;
      serial_sel_nxt = serial_load_sel;
      static_cfg_nxt[frc_pkg::CFG_OUT_W] = out_width_sel;
      static_cfg_nxt[frc_pkg::CFG_IN_W] = in_width_sel;
      static_cfg_nxt[frc_pkg::CFG_BUS_M] = bus_match_sel;
      static_cfg_nxt[frc_pkg::CFG_BYTE_O] = byte_order_sel;
      static_cfg_nxt[frc_pkg::CFG_FLAG_T] = flag_timing_sel;
      static_cfg_nxt[frc_pkg::CFG_PARITY] = interspersed_parity_sel;
      offset_nxt = {frc_pkg::AF_OFF_DEF[ADDR_W-1:0], frc_pkg::AE_OFF_DEF[ADDR_W-1:0]};
    end else if (serial_sel_r && sc_rise && !serial_enable_n) begin
      // Same in both timing modes; partial reset never touches this
      offset_nxt = {offset_r[2*ADDR_W-2:0], fallthrough_serial_pin};
    end
  end

  // Configuration registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fallthrough_timing_r <= 1'b0;
      wr_async_r <= 1'b0;
      rd_async_r <= 1'b0;
      serial_sel_r <= 1'b0;
      static_cfg_r <= '0;
      offset_r <= '0;
    end else begin
      fallthrough_timing_r <= fallthrough_timing_nxt;
      wr_async_r <= wr_async_nxt;
      rd_async_r <= rd_async_nxt;
      serial_sel_r <= serial_sel_nxt;
      static_cfg_r <= static_cfg_nxt;
      offset_r <= offset_nxt;
    end
  end

  // Async write port compares against the live read pointer
  assign rptr_seen = wr_async_r ? rptr_r : gray2bin(rgray_s2_r);
  assign wr_full = (wptr_r - rptr_seen) == DEPTH_P;
  // Slot of the marked word is protected while marked
  assign wr_blocked = (state_r != frc_pkg::RD_NORMAL) &&
                      (wptr_r[ADDR_W-1:0] == mark_ptr_r[ADDR_W-1:0]) &&
                      (wptr_r != mark_ptr_r);
  // Async port ignores enable, the writer keeps it low
  assign wr_go = wr_rise && (wr_async_r || !wen_n) && !wr_full &&
                 !wr_blocked && !any_rst;
  // Write pointer next state
  always_comb begin
    wptr_nxt = wptr_r;
    if (any_rst) wptr_nxt = '0;
    else if (wr_go) wptr_nxt = wptr_r + ONE_P;
    wgray_nxt = bin2gray(wptr_nxt);
  end

  // Write pointer and read-pointer synchroniser
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wptr_r <= '0;
      wgray_r <= '0;
      rgray_s1_r <= '0;
      rgray_s2_r <= '0;
    end else begin
      wptr_r <= wptr_nxt;
      wgray_r <= wgray_nxt;
      rgray_s1_r <= rgray_r;
      rgray_s2_r <= rgray_s1_r;
    end
  end
  // Storage write
  always_ff @(posedge mclk) begin
    if (wr_go) mem[wptr_r[ADDR_W-1:0]] <= d_in_bus;
  end
  // Async read port sees writes at once
  assign wptr_seen = rd_async_r ? wptr_r : gray2bin(wgray_s2_r);
  assign rd_avail = wptr_seen != rptr_r;
  // Async read port ignores enable and select, held low by reader
  assign rd_req = rd_async_r || (!ren_n && !read_select_n);

  // Read side next state: normal reads, fall-through, mark, replay
  always_comb begin
    state_nxt = state_r;
    rptr_nxt = rptr_r;
    mark_ptr_nxt = mark_ptr_r;
    ov_nxt = ov_r;
    ft_cnt_nxt = ft_cnt_r;
    q_nxt = q_r;
    rcs_on_nxt = rcs_on_r;
    if (any_rst) begin
      // Select has no effect on the outputs during reset
      state_nxt = frc_pkg::RD_NORMAL;
      rptr_nxt = '0;
      ov_nxt = 1'b0;
      ft_cnt_nxt = '0;
      q_nxt = '0;
      rcs_on_nxt = 1'b1;
    end else if (rd_fall) begin
      // Leaving marked mode happens on a falling edge only
      if (!mark) state_nxt = frc_pkg::RD_NORMAL;
    end else if (rd_rise) begin
      rcs_on_nxt = ~read_select_n;
      case (state_r)
        frc_pkg::RD_REPLAY: begin
          if (!replay_strobe_n) rptr_nxt = mark_ptr_r;
          else begin
            state_nxt = frc_pkg::RD_MARKED;
            if (fallthrough_timing_r) begin
              // Marked word falls through with no read request
              q_nxt = mem[mark_ptr_r[ADDR_W-1:0]];
              rptr_nxt = mark_ptr_r + ONE_P;
              ov_nxt = 1'b1;
            end
          end
        end
        frc_pkg::RD_MARKED: begin
          if (!replay_strobe_n) begin
            state_nxt = frc_pkg::RD_REPLAY;
            rptr_nxt = mark_ptr_r;
            ov_nxt = 1'b0;
            ft_cnt_nxt = '0;
          end else if (!fallthrough_timing_r && rd_req && rd_avail) begin
            q_nxt = mem[rptr_r[ADDR_W-1:0]];
            rptr_nxt = rptr_r + ONE_P;
          end else if (fallthrough_timing_r && ov_r && rd_req) begin
            ov_nxt = rd_avail;
            if (rd_avail) begin
              q_nxt = mem[rptr_r[ADDR_W-1:0]];
              rptr_nxt = rptr_r + ONE_P;
            end
          end
        end
        frc_pkg::RD_NORMAL: begin
          if (mark) begin
            // Word now in the output register is the last one taken
            state_nxt = frc_pkg::RD_MARKED;
            mark_ptr_nxt = rptr_r - ONE_P;
          end
          if (!fallthrough_timing_r) begin
            // Every word needs a request in standard timing
            if (rd_req && rd_avail) begin
              q_nxt = mem[rptr_r[ADDR_W-1:0]];
              rptr_nxt = rptr_r + ONE_P;
            end
          end else if (ov_r) begin
            if (rd_req) begin
              ov_nxt = rd_avail;
              if (rd_avail) begin
                q_nxt = mem[rptr_r[ADDR_W-1:0]];
                rptr_nxt = rptr_r + ONE_P;
              end
            end
          end else if (rd_avail) begin
            // First word into an empty buffer falls through by itself
            if (ft_cnt_r == frc_pkg::FT_EDGES - 2'h1) begin
              q_nxt = mem[rptr_r[ADDR_W-1:0]];
              rptr_nxt = rptr_r + ONE_P;
              ov_nxt = 1'b1;
              ft_cnt_nxt = '0;
            end else begin
              ft_cnt_nxt = ft_cnt_r + 2'h1;
            end
          end else begin
            ft_cnt_nxt = '0;
          end
        end
        default: begin
          state_nxt = frc_pkg::RD_NORMAL;
        end
      endcase
    end
    rgray_nxt = bin2gray(rptr_nxt);
  end

  // Read side registers and write-pointer synchroniser
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= frc_pkg::RD_NORMAL;
      rptr_r <= '0;
      rgray_r <= '0;
      mark_ptr_r <= '0;
      ov_r <= 1'b0;
      ft_cnt_r <= '0;
      q_r <= '0;
      rcs_on_r <= 1'b1;
      wgray_s1_r <= '0;
      wgray_s2_r <= '0;
    end else begin
      state_r <= state_nxt;
      rptr_r <= rptr_nxt;
      rgray_r <= rgray_nxt;
      mark_ptr_r <= mark_ptr_nxt;
      ov_r <= ov_nxt;
      ft_cnt_r <= ft_cnt_nxt;
      q_r <= q_nxt;
      rcs_on_r <= rcs_on_nxt;
      wgray_s1_r <= wgray_r;
      wgray_s2_r <= wgray_s1_r;
    end
  end

  // Fill level for the level flags, taken from live pointers
  assign level = wptr_r - rptr_r;
  // Mode to show: the pin itself while full reset is low
  assign ft_mode = full_rst ? fallthrough_serial_pin : fallthrough_timing_r;

  // Flag next state
  always_comb begin
    if (any_rst) begin
      // Empty, not full, in whichever timing mode applies
      ef_nxt = ft_mode;
      ff_nxt = ~ft_mode;
      ae_nxt = 1'b0;
      af_nxt = 1'b1;
      hf_nxt = 1'b1;
    end else begin
      if (ft_mode) begin
        ef_nxt = ~ov_r || (state_r == frc_pkg::RD_REPLAY);
        ff_nxt = wr_full;
      end else begin
        ef_nxt = rd_avail && (state_r != frc_pkg::RD_REPLAY);
        ff_nxt = ~wr_full;
      end
      ae_nxt = level > PW'(offset_r[ADDR_W-1:0]);
      af_nxt = level < (DEPTH_P - PW'(offset_r[2*ADDR_W-1:ADDR_W]));
      hf_nxt = level <= HALF_P;
    end
    // Output enable straight from oe in async read mode
    oe_nxt = rd_async_r ? ~oe_n : (~oe_n & rcs_on_r);
  end

  // Flag registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ef_r <= 1'b0;
      ff_r <= 1'b1;
      ae_r <= 1'b0;
      af_r <= 1'b1;
      hf_r <= 1'b1;
      oe_r <= 1'b0;
    end else begin
      ef_r <= ef_nxt;
      ff_r <= ff_nxt;
      ae_r <= ae_nxt;
      af_r <= af_nxt;
      hf_r <= hf_nxt;
      oe_r <= oe_nxt;
    end
  end

  // Outputs, each straight from a register
  assign q_out_bus = q_r;
  assign q_out_en = oe_r;
  assign empty_flag_n = ef_r;
  assign full_flag_n = ff_r;
  assign almost_empty_n = ae_r;
  assign almost_full_n = af_r;
  assign half_level_n = hf_r;
  assign fallthrough_timing = fallthrough_timing_r;
  assign static_cfg = static_cfg_r;
  assign offset_word = offset_r;
endmodule

/* File: tb/frc_port_model.sv */
`timescale 1ns/1ps
// Writer and reader logic on the two data ports
module frc_port_model (
  input logic mclk,
  input logic wasync,
  input logic rasync,
  output logic wclk_pin,
  output logic wen_n,
  output logic [frc_pkg::DATA_W-1:0] d_in_bus,
  output logic rclk_pin,
  output logic ren_n,
  output logic read_select_n,
  output logic mark,
  output logic replay_strobe_n
);
  // Idle levels, select always on
  initial begin
    wclk_pin = 1'h0;
    wen_n = 1'h1;
    d_in_bus = '0;
    rclk_pin = 1'h0;
    ren_n = 1'h1;
    read_select_n = 1'h0;
    mark = 1'h0;
    replay_strobe_n = 1'h1;
  end
  // One word per strobe; data scrambled once released
  task automatic wr(input logic [frc_pkg::DATA_W-1:0] d);
    @(posedge mclk);
    wclk_pin <= 1'h1;
    wen_n <= 1'h0;
    d_in_bus <= d;
    @(posedge mclk);
    wclk_pin <= 1'h0;
    wen_n <= !wasync;
    d_in_bus <= ~d;
  endtask
  // One read edge; mark and replay held until the next call
  task automatic rd(input logic en, input logic mk, input logic rt);
    @(posedge mclk);
    rclk_pin <= 1'h1;
    ren_n <= !(en || rasync);
    mark <= mk;
    replay_strobe_n <= rt;
    @(posedge mclk);
    rclk_pin <= 1'h0;
    ren_n <= !rasync;
  endtask
endmodule

/* File: tb/frc_assertions.sv */
`timescale 1ns/1ps
// Port checks for resets, mode latch, replay and serial offsets
module frc_checker #(
  parameter int ADDR_W = 14,
  parameter int DATA_W = 72
) (
  input logic mclk,
  input logic rst_n,
  input logic full_reset_n,
  input logic partial_reset_n,
  input logic fallthrough_serial_pin,
  input logic serial_clk_pin,
  input logic serial_enable_n,
  input logic rclk_pin,
  input logic mark,
  input logic replay_strobe_n,
  input logic [DATA_W-1:0] q_out_bus,
  input logic empty_flag_n,
  input logic full_flag_n,
  input logic almost_empty_n,
  input logic almost_full_n,
  input logic half_level_n,
  input logic fallthrough_timing,
  input logic [frc_pkg::CFG_W-1:0] static_cfg,
  input logic [2*ADDR_W-1:0] offset_word
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Two low samples first, so one edge of reset latency is allowed
  a_full_levels: assert property (
    !full_reset_n [*2] |=> !almost_empty_n && almost_full_n && half_level_n)
    else $error("full reset left level flags wrong");
  a_full_qzero: assert property (
    !full_reset_n [*2] |=> q_out_bus == '0) else $error("full reset kept output word");
  a_std_select: assert property (
    (!full_reset_n && !fallthrough_serial_pin) [*2] |=>
    !empty_flag_n && full_flag_n && !fallthrough_timing) else $error("standard mode flags wrong");
  a_ft_select: assert property (
    (!full_reset_n && fallthrough_serial_pin) [*2] |=>
    empty_flag_n && !full_flag_n && fallthrough_timing) else $error("fall-through flags wrong");
  // Outside full reset the latched selections never move
  a_cfg_frozen: assert property (
    full_reset_n && $past(full_reset_n) |-> $stable(static_cfg)) else $error("config moved");
  a_part_state: assert property (
    (full_reset_n && !partial_reset_n) [*2] |=> !almost_empty_n && almost_full_n
    && half_level_n && empty_flag_n == fallthrough_timing && full_flag_n != fallthrough_timing
    && $stable(fallthrough_timing)) else $error("partial reset state wrong");
  a_part_keep: assert property (
    (full_reset_n && !partial_reset_n) [*2] |=> q_out_bus == '0 && $stable(offset_word))
    else $error("partial reset lost offsets or kept output");
  // Offsets move only on an enabled serial clock rise
  a_shift_only: assert property (
    full_reset_n && !($rose(serial_clk_pin) && !serial_enable_n) |=> $stable(offset_word))
    else $error("offsets changed without a shift");
  a_q_hold: assert property (
    full_reset_n && partial_reset_n && !$rose(rclk_pin) |=> $stable(q_out_bus))
    else $error("output word changed without a read edge");
  a_std_replay: assert property (
    !fallthrough_timing && $rose(rclk_pin) && mark && $past(mark, 2) && !replay_strobe_n
    |-> ##[1:2] !empty_flag_n) else $error("empty flag not low in replay");
  a_ft_replay: assert property (
    fallthrough_timing && $rose(rclk_pin) && mark && $past(mark, 2) && !replay_strobe_n
    |-> ##[1:2] empty_flag_n) else $error("ready flag not high in replay");
  c_ft_reset: cover property (!full_reset_n && fallthrough_serial_pin);
  c_replay: cover property ($rose(rclk_pin) && mark && !replay_strobe_n);
  c_shift: cover property ($rose(serial_clk_pin) && !serial_enable_n);
endmodule
bind frc_ctrl frc_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_chk (.*);

/* File: tb/fifo_reset_mode_retransmit_ctrl_bench.sv */
`timescale 1ns/1ps
// Self-checking run: modes, strobe ports, replay, serial offsets
module fifo_reset_mode_retransmit_ctrl_bench;
  localparam int AW = 4; // Depth 16 keeps the fill short
  localparam int DW = frc_pkg::DATA_W;
  logic mclk = 1'h0;
  logic rst_n = 1'h0;
  logic full_reset_n = 1'h0; // Held low from power up
  logic partial_reset_n = 1'h1;
  logic fallthrough_serial_pin = 1'h0;
  logic serial_load_sel = 1'h0;
  logic serial_clk_pin = 1'h0;
  logic serial_enable_n = 1'h1;
  logic write_async_sel_n = 1'h1;
  logic read_async_sel_n = 1'h1;
  logic oe_n = 1'h0;
  logic out_width_sel = 1'h0, in_width_sel = 1'h0, bus_match_sel = 1'h0;
  logic byte_order_sel = 1'h0, flag_timing_sel = 1'h0, interspersed_parity_sel = 1'h0;
  logic wclk_pin, wen_n, rclk_pin, ren_n, read_select_n, mark, replay_strobe_n;
  logic [DW-1:0] d_in_bus, q_out_bus;
  logic q_out_en, empty_flag_n, full_flag_n, almost_empty_n, almost_full_n, half_level_n;
  logic fallthrough_timing;
  logic [frc_pkg::CFG_W-1:0] static_cfg;
  logic [2*AW-1:0] offset_word;
  // Reference queue: words kept, read index, marked index
  logic [DW-1:0] mem[$];
  int rp, mk, err_total, check_count;
  logic [31:0] lf = 32'h0000_42a7;
  logic [2*AW-1:0] ofs;

  frc_ctrl #(.ADDR_W(AW)) DUT (.*);
  frc_port_model pm (.*, .wasync(!write_async_sel_n), .rasync(!read_async_sel_n));

  always #5 mclk = ~mclk;

  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string n, input logic [DW-1:0] e, input logic [DW-1:0] s);
    check_count++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask
  // Full reset with random static selections, changed again afterwards
  task automatic frst(input logic ft, input logic wa, input logic ra, input logic sl);
    logic [5:0] c;
    lf = nx(lf);
    c = lf[5:0];
    @(posedge mclk);
    full_reset_n <= 1'h0;
    fallthrough_serial_pin <= ft;
    write_async_sel_n <= wa;
    read_async_sel_n <= ra;
    serial_load_sel <= sl;
    {interspersed_parity_sel, flag_timing_sel, byte_order_sel} <= c[5:3];
    {bus_match_sel, in_width_sel, out_width_sel} <= c[2:0];
    repeat (3) @(posedge mclk);
    full_reset_n <= 1'h1;
    fallthrough_serial_pin <= 1'h0;
    {interspersed_parity_sel, flag_timing_sel, byte_order_sel} <= ~c[5:3];
    {bus_match_sel, in_width_sel, out_width_sel} <= ~c[2:0];
    idle(2);
    chk("static_cfg", c, static_cfg);
    chk("q_out_bus", '0, q_out_bus);
    chk("empty_flag_n", ft, empty_flag_n);
    chk("full_flag_n", !ft, full_flag_n);
    chk("level flags", 3'h3, {almost_empty_n, almost_full_n, half_level_n});
    mem.delete();
    rp = 0;
    mk = -1; // No mark set yet
  endtask
  // Random words; the model keeps only what fits
  task automatic put(input int n);
    logic [DW-1:0] d;
    for (int i = 0; i < n; i++) begin
      lf = nx(lf);
      d = {lf[7:0], lf, ~lf};
      // While marked, a write never lands on the marked slot
      if (mem.size() - rp < (1 << AW) && (mk < 0 || mem.size() - mk < (1 << AW))) mem.push_back(d);
      pm.wr(d);
    end
  endtask
  task automatic get(input logic en, input logic m, input logic rt);
    pm.rd(en, m, rt);
    @(negedge mclk);
    if (en && rp < mem.size()) begin
      chk("q_out_bus", mem[rp], q_out_bus);
      rp++;
    end
  endtask
  // Mark word1, read on, replay, then check the marked word returns
  task automatic replay(input logic ft);
    frst(ft, 1'h1, 1'h1, 1'h0);
    // Margin ahead of the mark scaled down to the short depth
    put(6);
    idle(6);
    if (ft) begin
      repeat (3) pm.rd(1'h0, 1'h0, 1'h1);
      rp = 1;
    end else get(1'h1, 1'h0, 1'h1);
    get(1'h1, 1'h0, 1'h1);
    get(1'h0, 1'h1, 1'h1);
    mk = rp - 1;
    get(1'h1, 1'h1, 1'h1);
    // Overfill while marked; an overwrite would corrupt the replayed words
    put(13);
    repeat (2) get(1'h0, 1'h1, 1'h0);
    chk("empty_flag_n", ft, empty_flag_n);
    rp = mk;
    get(1'h0, 1'h1, 1'h1);
    idle(1);
    chk("empty_flag_n", !ft, empty_flag_n);
    if (ft) begin
      chk("q_out_bus", mem[mk], q_out_bus);
      rp++;
    end
    get(1'h1, 1'h1, 1'h1);
    get(1'h0, 1'h0, 1'h1);
    get(1'h1, 1'h0, 1'h1);
    $display("test replay mode %0d done", ft);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog well beyond the few hundred cycles the tests take
  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    complete_run();
  end

  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'h1;
    // Standard timing, every word needs a read request
    frst(1'h0, 1'h1, 1'h1, 1'h0);
    put(5);
    idle(6);
    repeat (5) get(1'h1, 1'h0, 1'h1);
    idle(6);
    chk("empty_flag_n", 1'h0, empty_flag_n);
    $display("test standard done");
    // Fall-through: first word lands on the third read edge
    frst(1'h1, 1'h1, 1'h1, 1'h0);
    put(2);
    idle(6);
    repeat (2) pm.rd(1'h0, 1'h0, 1'h1);
    idle(1);
    chk("q_out_bus", '0, q_out_bus);
    pm.rd(1'h0, 1'h0, 1'h1);
    idle(1);
    chk("q_out_bus", mem[0], q_out_bus);
    chk("empty_flag_n", 1'h0, empty_flag_n);
    rp = 1;
    get(1'h1, 1'h0, 1'h1);
    $display("test fall-through done");
    // Strobe ports: overfill, then drain to empty
    frst(1'h0, 1'h0, 1'h0, 1'h0);
    put(17);
    idle(2);
    chk("full_flag_n", 1'h0, full_flag_n);
    @(posedge mclk);
    oe_n <= 1'h1;
    idle(2);
    chk("q_out_en", 1'h0, q_out_en);
    @(posedge mclk);
    oe_n <= 1'h0;
    get(1'h1, 1'h0, 1'h1);
    idle(1);
    chk("full_flag_n", 1'h1, full_flag_n);
    repeat (15) get(1'h1, 1'h0, 1'h1);
    idle(1);
    chk("empty_flag_n", 1'h0, empty_flag_n);
    chk("q_out_en", 1'h1, q_out_en);
    $display("test strobe ports done");
    replay(1'h0);
    replay(1'h1);
    // Serial offsets, then a partial reset that must keep them
    frst(1'h0, 1'h1, 1'h1, 1'h1);
    ofs = {frc_pkg::AF_OFF_DEF[AW-1:0], frc_pkg::AE_OFF_DEF[AW-1:0]};
    chk("offset_word", ofs, offset_word);
    for (int i = 0; i < 2 * AW; i++) begin
      lf = nx(lf);
      @(posedge mclk);
      serial_enable_n <= lf[3];
      fallthrough_serial_pin <= lf[0];
      serial_clk_pin <= 1'h1;
      if (!lf[3]) ofs = {ofs[2*AW-2:0], lf[0]};
      @(posedge mclk);
      serial_clk_pin <= 1'h0;
    end
    idle(1);
    chk("offset_word", ofs, offset_word);
    put(2);
    idle(6);
    get(1'h1, 1'h0, 1'h1);
    @(posedge mclk);
    partial_reset_n <= 1'h0;
    repeat (3) @(posedge mclk);
    partial_reset_n <= 1'h1;
    idle(2);
    chk("offset_word", ofs, offset_word);
    chk("q_out_bus", '0, q_out_bus);
    chk("flags", 5'h0b, {empty_flag_n, full_flag_n, almost_empty_n, almost_full_n,
      half_level_n});
    $display("test serial and partial done");
    complete_run();
  end
endmodule
